// ==== rtl/scdr_regs.vh ====
// Register offsets, field positions and reset values of the calibration, diagnostic and id bank.
`ifndef SCDR_REGS_VH
`define SCDR_REGS_VH
`define SCDR_ADDR_ID 8'h00
`define SCDR_ADDR_LOOP_CURRENT_SETTING 8'h0a
`define SCDR_ADDR_CAL2 8'h0c
`define SCDR_ADDR_LINE_TEST_CONTROL 8'h0d
`define SCDR_CAL_RING_LEAK 5
`define SCDR_CAL_TIP_LEAK 4
`define SCDR_CAL_MONITOR 3
`define SCDR_CAL_DAC_OFS 2
`define SCDR_CAL_ADC_OFS 1
`define SCDR_CAL_BALANCE 0
`define SCDR_LINE_TEST_CONTROL_Q2_FINE 7
`define SCDR_LINE_TEST_CONTROL_Q1_FINE 6
`define SCDR_LINE_TEST_CONTROL_RING_TEST 5
`define SCDR_LINE_TEST_CONTROL_TX_FILT 4
`define SCDR_LINE_TEST_CONTROL_LINE_FILT 3
`define SCDR_SRC_TIP_V 3'h0
`define SCDR_SRC_RING_V 3'h1
`define SCDR_SRC_LOOP_V 3'h2
`define SCDR_SRC_LONG_V 3'h3
`define SCDR_SRC_LOOP_I 3'h4
`define SCDR_SRC_LONG_I 3'h5
`define SCDR_LOOP_CURRENT_SETTING_MAX 5'h1f
`define SCDR_RST_LOOP_CURRENT_SETTING 5'h00
`define SCDR_RST_CAL2 6'h00
`define SCDR_RST_LINE_TEST_CONTROL 8'h00
`define SCDR_CAL_TIME_NS 1000
`define SCDR_CAL_CYCLES (`SCDR_CAL_TIME_NS / 10)
`endif

// ==== rtl/scdr_cal_seq.v ====
// One calibration request bit: set by the host, cleared by hardware when its engine is done or its CAL_CYCLES count runs out.
module scdr_cal_seq #(
   parameter CAL_CYCLES = 100
) (
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // Host side
   input wire set_req,
   // Engine side
   input wire engine_done,
   output reg active,
   output reg start
);
   reg [15:0] count;
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         active <= 1'b0;
         start <= 1'b0;
         count <= 16'h0000;
      end
      else
      begin
         start <= set_req & ~active;
         if (set_req & ~active)
         begin
            active <= 1'b1;
            count <= CAL_CYCLES[15:0];
         end
         else if (active)
         begin
            if (engine_done || count == 16'h0001)
               active <= 1'b0;
            if (count != 16'h0000)
               count <= count - 16'h0001;
         end
      end
   end
endmodule

// ==== rtl/scdr_line_test_control_dec.v ====
// Decodes the line test source select into one-hot filter input enables.
`include "scdr_regs.vh"
module scdr_line_test_control_dec (
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // Control
   input wire enable,
   input wire [2:0] source,
   // Decoded selects
   output reg [5:0] select
);
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         select <= 6'h00;
      else if (!enable)
         select <= 6'h00;
      else
      begin
         case (source)
            `SCDR_SRC_TIP_V: select <= 6'h01;
            `SCDR_SRC_RING_V: select <= 6'h02;
            `SCDR_SRC_LOOP_V: select <= 6'h04;
            `SCDR_SRC_LONG_V: select <= 6'h08;
            `SCDR_SRC_LOOP_I: select <= 6'h10;
            `SCDR_SRC_LONG_I: select <= 6'h20;
            default: select <= 6'h00;
         endcase
      end
   end
endmodule

// ==== rtl/scdr_bank.v ====
// Calibration, line test, loop current and identification registers of one channel pair.
// Behaviour
// - Calibration bit 5 requests ring leakage calibration and reads one until it completes.
// - Calibration bit 4 requests tip leakage calibration and reads one until it completes.
// - Calibration bit 3 starts monitor converter calibration and reads one until it finishes.
// - Calibration bit 2 starts audio DAC offset calibration and reads one while active.
// - Calibration bit 1 starts audio ADC offset calibration and reads one while active.
// - Calibration bit 0 starts longitudinal balance calibration and reads one while active.
// - Line test bit 7 puts the monitor converter in fine range for the second transistor.
// - Line test bit 6 puts the monitor converter in fine range for the first transistor.
// - Line test bit 5 enables the low level test ringing generator.
// - Line test bit 4 enables the transmit path diagnostic filters.
// - Line test bit 3 enables the line side diagnostic filters.
// - Line test bits 2:0 pick the filter source from tip voltage to longitudinal current.
// - The identification register is shared and read only, part code 6:4 and revision 3:0.
// - The five bit loop current code sets 18 mA plus 0.875 mA per step.
`include "scdr_regs.vh"
module scdr_bank #(
   parameter [2:0] PART_CODE = 3'h5,
   parameter [3:0] REV_CODE = 4'h9,
   parameter CAL_CYCLES = `SCDR_CAL_CYCLES
) (
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // Register port from the serial control decoder
   input wire chan_sel,
   input wire [7:0] reg_addr,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_wdata,
   output reg [7:0] reg_rdata,
   output reg reg_rvalid,
   // Calibration engines, one bit per calibration, per channel
   input wire [5:0] cal_done_a,
   input wire [5:0] cal_done_b,
   output reg [5:0] cal_start_a,
   output reg [5:0] cal_start_b,
   // Analog controls, channel A
   output reg q2_fine_a,
   output reg q1_fine_a,
   output reg ring_test_a,
   output reg tx_filt_a,
   output reg [5:0] line_src_a,
   output reg [4:0] loop_current_setting_a,
   // Analog controls, channel B
   output reg q2_fine_b,
   output reg q1_fine_b,
   output reg ring_test_b,
   output reg tx_filt_b,
   output reg [5:0] line_src_b,
   output reg [4:0] loop_current_setting_b
);
   // ---------------------------------------------------------------
   // Storage and write decode
   // ---------------------------------------------------------------
   reg [7:0] line_test_control_a;
   reg [7:0] line_test_control_b;
   reg [4:0] loop_current_setting_reg_a;
   reg [4:0] loop_current_setting_reg_b;
   wire [5:0] cal_act_a;
   wire [5:0] cal_act_b;
   wire [5:0] cal_go_a;
   wire [5:0] cal_go_b;
   wire [5:0] src_a;
   wire [5:0] src_b;
   wire wr_cal = reg_wr && reg_addr == `SCDR_ADDR_CAL2;
   wire wr_cal_a = wr_cal && !chan_sel;
   wire wr_cal_b = wr_cal && chan_sel;

   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         line_test_control_a <= `SCDR_RST_LINE_TEST_CONTROL;
         line_test_control_b <= `SCDR_RST_LINE_TEST_CONTROL;
         loop_current_setting_reg_a <= `SCDR_RST_LOOP_CURRENT_SETTING;
         loop_current_setting_reg_b <= `SCDR_RST_LOOP_CURRENT_SETTING;
      end
      else if (reg_wr)
      begin
         if (reg_addr == `SCDR_ADDR_LINE_TEST_CONTROL && !chan_sel)
            line_test_control_a <= reg_wdata;
         if (reg_addr == `SCDR_ADDR_LINE_TEST_CONTROL && chan_sel)
            line_test_control_b <= reg_wdata;
         if (reg_addr == `SCDR_ADDR_LOOP_CURRENT_SETTING && !chan_sel)
            loop_current_setting_reg_a <= reg_wdata[4:0];
         if (reg_addr == `SCDR_ADDR_LOOP_CURRENT_SETTING && chan_sel)
            loop_current_setting_reg_b <= reg_wdata[4:0];
      end
   end

   // ---------------------------------------------------------------
   // Calibration request bits
   // ---------------------------------------------------------------
   // Writing zero never aborts a running calibration; only completion or the CAL_CYCLES limit clears a bit.
   genvar i;
   generate
      for (i = 0; i < 6; i = i + 1)
      begin : g_cal
         scdr_cal_seq #(.CAL_CYCLES(CAL_CYCLES)) u_a (
            .clk(clk),
            .rst_n(rst_n),
            .set_req(wr_cal_a & reg_wdata[i]),
            .engine_done(cal_done_a[i]),
            .active(cal_act_a[i]),
            .start(cal_go_a[i])
         );
         scdr_cal_seq #(.CAL_CYCLES(CAL_CYCLES)) u_b (
            .clk(clk),
            .rst_n(rst_n),
            .set_req(wr_cal_b & reg_wdata[i]),
            .engine_done(cal_done_b[i]),
            .active(cal_act_b[i]),
            .start(cal_go_b[i])
         );
      end
   endgenerate

   // ---------------------------------------------------------------
   // Line test source decode
   // ---------------------------------------------------------------
   scdr_line_test_control_dec u_dec_a (
      .clk(clk),
      .rst_n(rst_n),
      .enable(line_test_control_a[`SCDR_LINE_TEST_CONTROL_LINE_FILT]),
      .source(line_test_control_a[2:0]),
      .select(src_a)
   );
   scdr_line_test_control_dec u_dec_b (
      .clk(clk),
      .rst_n(rst_n),
      .enable(line_test_control_b[`SCDR_LINE_TEST_CONTROL_LINE_FILT]),
      .source(line_test_control_b[2:0]),
      .select(src_b)
   );

   // ---------------------------------------------------------------
   // Registered control outputs
   // ---------------------------------------------------------------
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cal_start_a <= 6'h00;
         cal_start_b <= 6'h00;
         q2_fine_a <= 1'b0;
         q1_fine_a <= 1'b0;
         ring_test_a <= 1'b0;
         tx_filt_a <= 1'b0;
         line_src_a <= 6'h00;
         loop_current_setting_a <= `SCDR_RST_LOOP_CURRENT_SETTING;
         q2_fine_b <= 1'b0;
         q1_fine_b <= 1'b0;
         ring_test_b <= 1'b0;
         tx_filt_b <= 1'b0;
         line_src_b <= 6'h00;
         loop_current_setting_b <= `SCDR_RST_LOOP_CURRENT_SETTING;
      end
      else
      begin
         cal_start_a <= cal_go_a;
         cal_start_b <= cal_go_b;
         q2_fine_a <= line_test_control_a[`SCDR_LINE_TEST_CONTROL_Q2_FINE];
         q1_fine_a <= line_test_control_a[`SCDR_LINE_TEST_CONTROL_Q1_FINE];
         ring_test_a <= line_test_control_a[`SCDR_LINE_TEST_CONTROL_RING_TEST];
         tx_filt_a <= line_test_control_a[`SCDR_LINE_TEST_CONTROL_TX_FILT];
         line_src_a <= src_a;
         loop_current_setting_a <= loop_current_setting_reg_a;
         q2_fine_b <= line_test_control_b[`SCDR_LINE_TEST_CONTROL_Q2_FINE];
         q1_fine_b <= line_test_control_b[`SCDR_LINE_TEST_CONTROL_Q1_FINE];
         ring_test_b <= line_test_control_b[`SCDR_LINE_TEST_CONTROL_RING_TEST];
         tx_filt_b <= line_test_control_b[`SCDR_LINE_TEST_CONTROL_TX_FILT];
         line_src_b <= src_b;
         loop_current_setting_b <= loop_current_setting_reg_b;
      end
   end

   // ---------------------------------------------------------------
   // Read path
   // ---------------------------------------------------------------
   reg [7:0] next_rdata;
   always @*
   begin
      next_rdata = 8'h00;
      case (reg_addr)
         `SCDR_ADDR_ID: next_rdata = {1'b0, PART_CODE, REV_CODE};
         `SCDR_ADDR_LOOP_CURRENT_SETTING: next_rdata = {3'h0, chan_sel ? loop_current_setting_reg_b : loop_current_setting_reg_a};
         `SCDR_ADDR_CAL2: next_rdata = {2'h0, chan_sel ? cal_act_b : cal_act_a};
         `SCDR_ADDR_LINE_TEST_CONTROL: next_rdata = chan_sel ? line_test_control_b : line_test_control_a;
         default: next_rdata = 8'h00;
      endcase
   end

   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         reg_rdata <= 8'h00;
         reg_rvalid <= 1'b0;
      end
      else
      begin
         reg_rvalid <= reg_rd;
         if (reg_rd)
            reg_rdata <= next_rdata;
      end
   end
endmodule

// ==== dv/scdr_bank_chk.sv ====
// Checker for the register port and channel A controls of the bank.
module scdr_bank_chk #(
   parameter [2:0] PART_CODE = 3'h5,
   parameter [3:0] REV_CODE = 4'h9,
   parameter CAL_CYCLES = 100
) (
   // Clock, reset and register port
   input wire clk, rst_n, chan_sel, reg_wr, reg_rd, reg_rvalid,
   input wire [7:0] reg_addr, reg_wdata, reg_rdata,
   // Channel A controls
   input wire q2_fine_a, q1_fine_a, ring_test_a, tx_filt_a,
   input wire [5:0] cal_start_a, line_src_a,
   input wire [4:0] loop_current_setting_a
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   sequence s_wr_a(a);
      reg_wr && !chan_sel && reg_addr == a;
   endsequence
   a_rd_answer: assert property (reg_rd |=> reg_rvalid)
      else $error("read strobe not answered");
   a_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd))
      else $error("read answer without strobe");
   a_id_value: assert property (
      reg_rd && reg_addr == 8'h00 |=> reg_rdata == {1'b0, PART_CODE, REV_CODE})
      else $error("identity read wrong");
   a_loop_current_setting_update: assert property (
      s_wr_a(8'h0a) |-> ##2 loop_current_setting_a == $past(reg_wdata[4:0], 2))
      else $error("loop current not updated");
   a_line_test_control_levels: assert property (
      s_wr_a(8'h0d) |-> ##2 {q2_fine_a, q1_fine_a, ring_test_a, tx_filt_a} ==
      $past(reg_wdata[7:4], 2))
      else $error("line test levels not updated");
   a_src_onehot: assert property ($onehot0(line_src_a))
      else $error("several filter sources");
   // The source select passes the register, the decoder and the output flop: three edges.
   a_src_gated: assert property (
      s_wr_a(8'h0d) ##0 !reg_wdata[3] |-> ##3 line_src_a == 6'h00)
      else $error("filter source without enable");
   a_start_cause: assert property (
      |cal_start_a |-> $past(reg_wr && !chan_sel && reg_addr == 8'h0c, 2))
      else $error("calibration start without request");
   a_start_pulse: assert property ((cal_start_a & $past(cal_start_a)) == 6'h00)
      else $error("calibration start held");
endmodule
bind scdr_bank scdr_bank_chk #(.PART_CODE(PART_CODE), .REV_CODE(REV_CODE),
   .CAL_CYCLES(CAL_CYCLES)) chk (.*);

// ==== dv/scdr_cal_engine.sv ====
// Calibration engine model: answers each start with a done pulse after a set delay.
module scdr_cal_engine (
   // Clock, reset and bank side
   input wire clk,
   input wire rst_n,
   input wire [5:0] start,
   output reg [5:0] done,
   // Delay in cycles; zero never answers
   input wire [7:0] delay
);
   timeunit 1ns;
   timeprecision 1ns;
   reg [7:0] cnt;
   reg [5:0] pend;
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt <= 8'h00;
         pend <= 6'h00;
         done <= 6'h00;
      end
      else
      begin
         done <= (cnt == 8'h01) ? pend : 6'h00;
         pend <= (cnt == 8'h01) ? start : (pend | start);
         cnt <= (|start) ? delay : ((cnt == 8'h00) ? cnt : cnt - 8'h01);
      end
   end
endmodule

// ==== dv/scdr_bank_bench.sv ====
// Self-checking bench of the calibration, line test and id register bank.
module scdr_bank_bench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam [2:0] PC = 3'h2; // Arbitrary part code.
   localparam [3:0] RC = 4'h6; // Arbitrary revision code.
   reg clk = 1'b0;
   reg rst_n, chan_sel, reg_wr, reg_rd;
   reg [7:0] reg_addr, reg_wdata, dly_a, dly_b, rd_val;
   wire reg_rvalid;
   wire [7:0] reg_rdata;
   wire [5:0] done_a, done_b, start_a, start_b, src_a, src_b;
   wire [4:0] loop_current_setting_a, loop_current_setting_b;
   wire [3:0] dg_a, dg_b;
   integer n_mismatch = 0;
   integer n_checks = 0;
   integer i, k;
   scdr_bank #(.PART_CODE(PC), .REV_CODE(RC), .CAL_CYCLES(20)) dut (
      .clk(clk), .rst_n(rst_n), .chan_sel(chan_sel), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .cal_done_a(done_a), .cal_done_b(done_b), .cal_start_a(start_a), .cal_start_b(start_b),
      .q2_fine_a(dg_a[3]), .q1_fine_a(dg_a[2]), .ring_test_a(dg_a[1]), .tx_filt_a(dg_a[0]),
      .line_src_a(src_a), .loop_current_setting_a(loop_current_setting_a), .q2_fine_b(dg_b[3]), .q1_fine_b(dg_b[2]),
      .ring_test_b(dg_b[1]), .tx_filt_b(dg_b[0]), .line_src_b(src_b), .loop_current_setting_b(loop_current_setting_b));
   scdr_cal_engine eng_a (.clk(clk), .rst_n(rst_n), .start(start_a), .done(done_a),
      .delay(dly_a));
   scdr_cal_engine eng_b (.clk(clk), .rst_n(rst_n), .start(start_b), .done(done_b),
      .delay(dly_b));
   initial forever #5 clk = ~clk;
   task end_of_test;
   begin
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   end
   endtask
   task chk(input string nm, input [7:0] e, input [7:0] g);
   begin
      n_checks = n_checks + 1;
      if (g !== e)
      begin
         n_mismatch = n_mismatch + 1;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   end
   endtask
   task wr(input ch, input [7:0] a, input [7:0] d);
   begin
      chan_sel <= ch;
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   end
   endtask
   task rd(input ch, input [7:0] a);
   begin
      chan_sel <= ch;
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk("rvalid", 8'h01, {7'h00, reg_rvalid});
      rd_val = reg_rdata;
      @(posedge clk);
   end
   endtask
   task rc(input string nm, input ch, input [7:0] a, input [7:0] e);
   begin
      rd(ch, a);
      chk(nm, e, rd_val);
   end
   endtask
   task poll(input ch);
   begin
      k = 0;
      rd(ch, 8'h0c);
      while (rd_val !== 8'h00 && k < 40)
      begin
         rd(ch, 8'h0c);
         k = k + 1;
      end
      chk("cal done", 8'h00, rd_val);
      if (rd_val !== 8'h00)
         end_of_test;
   end
   endtask
   initial
   begin
      rst_n = 1'b0;
      chan_sel = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      dly_a = 8'h03;
      dly_b = 8'h00;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      for (i = 0; i < 2; i = i + 1)
      begin
         rc("loop_current_setting", i[0], 8'h0a, 8'h00);
         rc("cal", i[0], 8'h0c, 8'h00);
         rc("line_test_control", i[0], 8'h0d, 8'h00);
         rc("id", i[0], 8'h00, {1'b0, PC, RC});
      end
      wr(1'b0, 8'h00, 8'h00);
      rc("id kept", 1'b1, 8'h00, {1'b0, PC, RC});
      rc("unmapped", 1'b0, 8'h33, 8'h00);
      $display("test reset done");
      wr(1'b0, 8'h0a, 8'hff);
      wr(1'b1, 8'h0a, 8'h09);
      rc("loop_current_setting a", 1'b0, 8'h0a, 8'h1f);
      rc("loop_current_setting b", 1'b1, 8'h0a, 8'h09);
      chk("loop_current_setting out a", 8'h1f, {3'h0, loop_current_setting_a});
      chk("loop_current_setting out b", 8'h09, {3'h0, loop_current_setting_b});
      $display("test loop current done");
      for (i = 0; i < 8; i = i + 1)
      begin
         wr(1'b0, 8'h0d, {4'ha, 1'b1, i[2:0]});
         rc("line_test_control", 1'b0, 8'h0d, {4'ha, 1'b1, i[2:0]});
         chk("line src", (i < 6) ? 8'h01 << i : 8'h00, {2'h0, src_a});
         chk("line_test_control outs", 8'h0a, {4'h0, dg_a});
      end
      wr(1'b0, 8'h0d, 8'h55);
      rc("line_test_control", 1'b0, 8'h0d, 8'h55);
      chk("src off", 8'h00, {2'h0, src_a});
      chk("line_test_control outs", 8'h05, {4'h0, dg_a});
      chk("line_test_control b", 8'h00, {src_b[3:0], dg_b});
      wr(1'b1, 8'h0d, 8'h5c);
      rc("line_test_control b wr", 1'b1, 8'h0d, 8'h5c);
      chk("src b", 8'h10, {2'h0, src_b});
      chk("line_test_control outs b", 8'h05, {4'h0, dg_b});
      chk("line_test_control outs a", 8'h05, {4'h0, dg_a});
      $display("test line test done");
      wr(1'b0, 8'h0c, 8'hff);
      #1;
      chk("start a", 8'h3f, {2'h0, start_a});
      @(posedge clk);
      rc("cal busy", 1'b0, 8'h0c, 8'h3f);
      poll(1'b0);
      wr(1'b1, 8'h0c, 8'h08);
      #1;
      chk("start b", 8'h08, {2'h0, start_b});
      @(posedge clk);
      wr(1'b1, 8'h0c, 8'h08);
      #1;
      chk("start b busy", 8'h00, {2'h0, start_b});
      @(posedge clk);
      wr(1'b1, 8'h0c, 8'h00);
      rc("cal kept", 1'b1, 8'h0c, 8'h08);
      poll(1'b1);
      $display("test calibration done");
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rc("loop_current_setting rst", 1'b0, 8'h0a, 8'h00);
      rc("line_test_control rst", 1'b1, 8'h0d, 8'h00);
      chk("outs rst", 8'h00, {src_b[3:0], dg_b});
      chk("loop_current_setting out rst", 8'h00, {3'h0, loop_current_setting_a});
      $display("test mid reset done");
      end_of_test;
   end
endmodule
